// >>> logic/alu_subset.sv
// Purpose: Execution datapath for a subset of an 8-bit CPU instruction set
// Assumes: Decoder holds i_start for one cycle and waits for o_done before the next
// Notes: Results and flags are written on the o_done cycle; all outputs registered
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// [RL1] Word add-immediate treats a register pair as 16 bits, sets Z C N V S, takes two cycles.
// [RL2] Word subtract-immediate treats a register pair as 16 bits, sets Z C N V S, takes two cycles.
// [RL3] Subtract-immediate-with-borrow removes constant and carry, sets Z C N V S H in one cycle.
// [RL4] AND-immediate writes back the result, sets Z N V S only, in one cycle.
// [RL5] OR-immediate writes back the result, sets Z N V S only, in one cycle.
// [RL6] Set-mask-bits ORs in the mask, sets Z N V S, in one cycle.
// [RL7] Clear-mask-bits ANDs with the inverted mask, sets Z N V S, in one cycle.
// [RL8] Test ANDs a register with itself, keeps it, sets Z N V S, in one cycle.
// [RL9] Mixed multiply is signed by unsigned, 16-bit product to the low pair, sets Z C, two cycles.
// [RL10] Fractional mixed multiply shifts that product left by one, sets Z C, two cycles.
// [RL11] Extended indirect jump loads Z into the low PC and the high register above, two cycles.
// [RL12] Indirect jump loads Z into the low PC and zero above, no flags, two cycles.
// [RL13] Unlisted flags keep their values and Z is set exactly when the stored result is zero.
module alu_subset (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_start,
    input wire alu_subset_pkg::alu_op_t i_op,
    input wire logic [15:0] i_opa,
    input wire logic [7:0] i_opb,
    input wire logic [15:0] i_z_ptr,
    input wire logic [5:0] i_ext_indirect_high,
    input wire logic [5:0] i_flags,
    output logic o_busy,
    output logic o_done,
    output logic [15:0] o_result,
    output logic o_wr_byte,
    output logic o_wr_word,
    output logic o_wr_low_pair,
    output logic [5:0] o_flags,
    output logic o_flags_we,
    output logic [21:0] o_pc,
    output logic o_pc_we
);
    typedef enum logic [0:0] {ST_IDLE, ST_SECOND} state_t;

    state_t state_q, state_d;
    alu_subset_pkg::alu_op_t op_q, op_d;
    logic [15:0] opa_q, opa_d;
    logic [7:0] opb_q, opb_d;
    logic [15:0] z_q, z_d;
    logic [5:0] eh_q, eh_d;
    logic [5:0] fin_q, fin_d;
    logic busy_q, busy_d;
    logic done_q, done_d;
    logic [15:0] res_q, res_d;
    logic wrb_q, wrb_d, wrw_q, wrw_d, wrp_q, wrp_d;
    logic [5:0] flg_q, flg_d;
    logic fwe_q, fwe_d;
    logic [21:0] pc_q, pc_d;
    logic pwe_q, pwe_d;

    // Logic flags: V cleared, N from msb, S = N ^ V, Z from result
    function automatic logic [5:0] logic_flags(input logic [7:0] r, input logic [5:0] f);
        logic [5:0] o;
        o = f;
        o[alu_subset_pkg::FLAG_Z] = (r == 8'h00);
        o[alu_subset_pkg::FLAG_N] = r[7];
        o[alu_subset_pkg::FLAG_V] = 1'b0;
        o[alu_subset_pkg::FLAG_S] = r[7];
        return o;
    endfunction

    // Mixed signed (a) by unsigned (b) product
    function automatic logic [15:0] mul_su(input logic [7:0] a, input logic [7:0] b);
        logic signed [16:0] p;
        p = $signed({{9{a[7]}}, a}) * $signed({9'h000, b});
        return p[15:0];
    endfunction

    // Single-cycle operations and the second cycle of two-cycle ones
    always_comb begin
        logic [16:0] w;
        logic [8:0] d;
        logic [15:0] p;
        logic [7:0] r;
        logic [5:0] f;
        w = 17'h00000;
        d = 9'h000;
        p = 16'h0000;
        r = 8'h00;
        f = i_flags;
        state_d = state_q;
        op_d = op_q;
        opa_d = opa_q;
        opb_d = opb_q;
        z_d = z_q;
        eh_d = eh_q;
        fin_d = fin_q;
        busy_d = 1'b0;
        done_d = 1'b0;
        res_d = res_q;
        wrb_d = 1'b0;
        wrw_d = 1'b0;
        wrp_d = 1'b0;
        flg_d = flg_q;
        fwe_d = 1'b0;
        pc_d = pc_q;
        pwe_d = 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                if (i_start) begin
                    unique case (i_op)
                        alu_subset_pkg::OP_SUB_IMM_BORROW: begin
                            d = {1'b0, i_opa[7:0]} - {1'b0, i_opb}
                                - {8'h00, i_flags[alu_subset_pkg::FLAG_C]}; // [RL3]
                            r = d[7:0];
                            f[alu_subset_pkg::FLAG_C] = d[8]; // [RL3]
                            f[alu_subset_pkg::FLAG_Z] = (r == 8'h00); // [RL13]
                            f[alu_subset_pkg::FLAG_N] = r[7];
                            f[alu_subset_pkg::FLAG_V] = (i_opa[7] & ~i_opb[7] & ~r[7])
                                | (~i_opa[7] & i_opb[7] & r[7]);
                            f[alu_subset_pkg::FLAG_S] = r[7] ^ f[alu_subset_pkg::FLAG_V];
                            f[alu_subset_pkg::FLAG_H] = (~i_opa[3] & i_opb[3])
                                | (i_opb[3] & r[3]) | (r[3] & ~i_opa[3]);
                            res_d = {8'h00, r};
                            flg_d = f;
                            wrb_d = 1'b1;
                            fwe_d = 1'b1;
                            done_d = 1'b1;
                        end
                        alu_subset_pkg::OP_AND_IMM,
                        alu_subset_pkg::OP_OR_IMM,
                        alu_subset_pkg::OP_SET_MASK_BITS,
                        alu_subset_pkg::OP_CLEAR_MASK_BITS,
                        alu_subset_pkg::OP_TEST_ZERO_MINUS: begin
                            unique case (i_op)
                                alu_subset_pkg::OP_AND_IMM: r = i_opa[7:0] & i_opb; // [RL4]
                                alu_subset_pkg::OP_OR_IMM: r = i_opa[7:0] | i_opb; // [RL5]
                                alu_subset_pkg::OP_SET_MASK_BITS: r = i_opa[7:0] | i_opb; // [RL6]
                                alu_subset_pkg::OP_CLEAR_MASK_BITS: r = i_opa[7:0] & ~i_opb; // [RL7]
                                default: r = i_opa[7:0] & i_opa[7:0]; // [RL8]
                            endcase
                            res_d = {8'h00, r};
                            flg_d = logic_flags(r, i_flags); // [RL13]
                            wrb_d = (i_op != alu_subset_pkg::OP_TEST_ZERO_MINUS); // [RL8]
                            fwe_d = 1'b1;
                            done_d = 1'b1;
                        end
                        alu_subset_pkg::OP_NONE: begin
                        end
                        default: begin
                            op_d = i_op;
                            opa_d = i_opa;
                            opb_d = i_opb;
                            z_d = i_z_ptr;
                            eh_d = i_ext_indirect_high;
                            fin_d = i_flags;
                            busy_d = 1'b1;
                            state_d = ST_SECOND;
                        end
                    endcase
                end
            end
            ST_SECOND: begin
                f = fin_q;
                state_d = ST_IDLE;
                done_d = 1'b1;
                unique case (op_q)
                    alu_subset_pkg::OP_ADD_IMM_WORD,
                    alu_subset_pkg::OP_SUB_IMM_WORD: begin
                        if (op_q == alu_subset_pkg::OP_ADD_IMM_WORD) begin
                            w = {1'b0, opa_q} + {9'h000, opb_q}; // [RL1]
                        end else begin
                            w = {1'b0, opa_q} - {9'h000, opb_q}; // [RL2]
                        end
                        f[alu_subset_pkg::FLAG_C] = w[16];
                        f[alu_subset_pkg::FLAG_Z] = (w[15:0] == 16'h0000); // [RL13]
                        f[alu_subset_pkg::FLAG_N] = w[15];
                        f[alu_subset_pkg::FLAG_V] = (op_q == alu_subset_pkg::OP_ADD_IMM_WORD)
                            ? (~opa_q[15] & w[15]) : (opa_q[15] & ~w[15]);
                        f[alu_subset_pkg::FLAG_S] = w[15] ^ f[alu_subset_pkg::FLAG_V];
                        res_d = w[15:0];
                        wrw_d = 1'b1;
                        flg_d = f;
                        fwe_d = 1'b1;
                    end
                    alu_subset_pkg::OP_MUL_MIXED_SIGN,
                    alu_subset_pkg::OP_FRAC_MUL_MIXED_SIGN: begin
                        p = mul_su(opa_q[7:0], opb_q); // [RL9]
                        f[alu_subset_pkg::FLAG_C] = p[15];
                        if (op_q == alu_subset_pkg::OP_FRAC_MUL_MIXED_SIGN) begin
                            p = {p[14:0], 1'b0}; // [RL10]
                        end
                        f[alu_subset_pkg::FLAG_Z] = (p == 16'h0000); // [RL13]
                        res_d = p;
                        wrp_d = 1'b1;
                        flg_d = f;
                        fwe_d = 1'b1;
                    end
                    alu_subset_pkg::OP_EXT_INDIRECT_JUMP: begin
                        pc_d = {eh_q, z_q}; // [RL11]
                        pwe_d = 1'b1;
                    end
                    alu_subset_pkg::OP_INDIRECT_JUMP: begin
                        pc_d = {6'h00, z_q}; // [RL12]
                        pwe_d = 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            state_q <= ST_IDLE;
            op_q <= alu_subset_pkg::OP_NONE;
            opa_q <= 16'h0000;
            opb_q <= 8'h00;
            z_q <= 16'h0000;
            eh_q <= 6'h00;
            fin_q <= alu_subset_pkg::FLAGS_RESET;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            res_q <= 16'h0000;
            wrb_q <= 1'b0;
            wrw_q <= 1'b0;
            wrp_q <= 1'b0;
            flg_q <= alu_subset_pkg::FLAGS_RESET;
            fwe_q <= 1'b0;
            pc_q <= alu_subset_pkg::PC_RESET;
            pwe_q <= 1'b0;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            opa_q <= opa_d;
            opb_q <= opb_d;
            z_q <= z_d;
            eh_q <= eh_d;
            fin_q <= fin_d;
            busy_q <= busy_d;
            done_q <= done_d;
            res_q <= res_d;
            wrb_q <= wrb_d;
            wrw_q <= wrw_d;
            wrp_q <= wrp_d;
            flg_q <= flg_d;
            fwe_q <= fwe_d;
            pc_q <= pc_d;
            pwe_q <= pwe_d;
        end
    end

    assign o_busy = busy_q;
    assign o_done = done_q;
    assign o_result = res_q;
    assign o_wr_byte = wrb_q;
    assign o_wr_word = wrw_q;
    assign o_wr_low_pair = wrp_q;
    assign o_flags = flg_q;
    assign o_flags_we = fwe_q;
    assign o_pc = pc_q;
    assign o_pc_we = pwe_q;

    a_word_two_cycles: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (i_start && !busy_q && state_q == ST_IDLE
         && i_op == alu_subset_pkg::OP_ADD_IMM_WORD) |-> ##2 (done_q && wrw_q))
        else $error("word add not done in two cycles"); // [RL1]
    a_word_sub_value: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (state_q == ST_IDLE && i_start && i_op == alu_subset_pkg::OP_SUB_IMM_WORD)
        |-> ##2 (res_q == 16'($past(i_opa, 2) - {8'h00, $past(i_opb, 2)})))
        else $error("word subtract result wrong"); // [RL2]
    a_borrow_one_cycle: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (state_q == ST_IDLE && i_start && i_op == alu_subset_pkg::OP_SUB_IMM_BORROW)
        |=> (done_q && wrb_q
             && res_q[7:0] == 8'($past(i_opa[7:0]) - $past(i_opb) - $past(i_flags[0]))))
        else $error("borrow subtract wrong"); // [RL3]
    a_and_imm_value: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (state_q == ST_IDLE && i_start && i_op == alu_subset_pkg::OP_AND_IMM)
        |=> (res_q[7:0] == ($past(i_opa[7:0]) & $past(i_opb)) && !flg_q[3]
             && flg_q[0] == $past(i_flags[0])))
        else $error("and immediate wrong"); // [RL4]
    a_or_imm_value: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (state_q == ST_IDLE && i_start && i_op == alu_subset_pkg::OP_OR_IMM)
        |=> (done_q && res_q[7:0] == ($past(i_opa[7:0]) | $past(i_opb))))
        else $error("or immediate wrong"); // [RL5]
    a_clear_mask_value: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (state_q == ST_IDLE && i_start && i_op == alu_subset_pkg::OP_CLEAR_MASK_BITS)
        |=> (res_q[7:0] == ($past(i_opa[7:0]) & ~$past(i_opb))))
        else $error("clear mask wrong"); // [RL7]
    a_test_no_write: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (state_q == ST_IDLE && i_start && i_op == alu_subset_pkg::OP_TEST_ZERO_MINUS)
        |=> (!wrb_q && fwe_q && flg_q[1] == ($past(i_opa[7:0]) == 8'h00)))
        else $error("test wrote register or bad zero"); // [RL8]
    a_mul_low_pair: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (state_q == ST_IDLE && i_start && i_op == alu_subset_pkg::OP_MUL_MIXED_SIGN)
        |-> ##2 (wrp_q && flg_q[1] == (res_q == 16'h0000)))
        else $error("mixed multiply wrong"); // [RL9]
    a_frac_lsb_zero: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (wrp_q && op_q == alu_subset_pkg::OP_FRAC_MUL_MIXED_SIGN) |-> !res_q[0])
        else $error("fractional product not shifted"); // [RL10]
    a_jump_pc_load: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (state_q == ST_IDLE && i_start && i_op == alu_subset_pkg::OP_INDIRECT_JUMP)
        |-> ##2 (pwe_q && !fwe_q && pc_q == {6'h00, $past(i_z_ptr, 2)}))
        else $error("indirect jump wrong"); // [RL12]
    a_ext_jump_load: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (state_q == ST_IDLE && i_start && i_op == alu_subset_pkg::OP_EXT_INDIRECT_JUMP)
        |-> ##2 (pwe_q && !fwe_q && pc_q[21:16] == $past(i_ext_indirect_high, 2)))
        else $error("extended jump wrong"); // [RL11]
    a_set_mask_value: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (state_q == ST_IDLE && i_start && i_op == alu_subset_pkg::OP_SET_MASK_BITS)
        |=> (res_q[7:0] == ($past(i_opa[7:0]) | $past(i_opb))))
        else $error("set mask wrong"); // [RL6]
    a_zero_flag_byte: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        wrb_q |-> (flg_q[1] == (res_q[7:0] == 8'h00)))
        else $error("zero flag mismatch"); // [RL13]
endmodule

`default_nettype wire

// >>> shared/alu_subset_pkg.sv
// Purpose: Constants and operation codes for the ALU instruction subset
// Assumes: One 20 MHz core clock, synchronous reset
// Notes: Flag vector order is {h, s, v, n, z, c}
package alu_subset_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int CYC_WORD = 2;
    localparam int CYC_BYTE = 1;
    localparam int CYC_MUL = 2;
    localparam int CYC_JUMP = 2;
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam logic [5:0] FLAGS_RESET = 6'h00;
    localparam logic [21:0] PC_RESET = 22'h000000;
    typedef enum logic [3:0] {
        OP_NONE,
        OP_ADD_IMM_WORD,
        OP_SUB_IMM_WORD,
        OP_SUB_IMM_BORROW,
        OP_AND_IMM,
        OP_OR_IMM,
        OP_SET_MASK_BITS,
        OP_CLEAR_MASK_BITS,
        OP_TEST_ZERO_MINUS,
        OP_MUL_MIXED_SIGN,
        OP_FRAC_MUL_MIXED_SIGN,
        OP_EXT_INDIRECT_JUMP,
        OP_INDIRECT_JUMP
    } alu_op_t;
endpackage

// >>> verification/reg_file_model.sv
// Purpose: Register file and flag store on the far side of the ALU subset
// Assumes: Write strobes from the datapath are one-cycle pulses
// Notes: The bench preloads the flags through i_load before each check_op request and once before the two jumps; t_seq does not
`timescale 1ns/10ps
`default_nettype none
module reg_file_model (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_load,
    input wire logic [5:0] i_load_flags,
    input wire logic [15:0] i_result,
    input wire logic i_wr_byte,
    input wire logic i_wr_word,
    input wire logic i_wr_low_pair,
    input wire logic [5:0] i_flags,
    input wire logic i_flags_we,
    input wire logic [21:0] i_pc,
    input wire logic i_pc_we,
    output logic [7:0] o_byte,
    output logic [15:0] o_word,
    output logic [15:0] o_low_pair,
    output logic [5:0] o_flags,
    output logic [21:0] o_pc
);
    always @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_byte <= 8'h00;
            o_word <= 16'h0000;
            o_low_pair <= 16'h0000;
            o_flags <= 6'h00;
            o_pc <= 22'h000000;
        end else begin
            if (i_wr_byte) o_byte <= i_result[7:0];
            if (i_wr_word) o_word <= i_result;
            if (i_wr_low_pair) o_low_pair <= i_result;
            if (i_pc_we) o_pc <= i_pc;
            // Flags take the load strobe first, else the flags write strobe, otherwise they are kept
            if (i_load) o_flags <= i_load_flags;
            else if (i_flags_we) o_flags <= i_flags;
        end
    end
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Purpose: Self-checking bench for the ALU subset
// Assumes: One request at a time, next one after o_done, except t_seq, which also starts one while busy
// Notes: Expected values come from the bench's own arithmetic
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int LIMIT = 4000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic go = 1'b0;
    alu_subset_pkg::alu_op_t op_s = alu_subset_pkg::OP_NONE;
    logic [15:0] a_s = 16'h0000;
    logic [7:0] b_s = 8'h00;
    logic [15:0] zp = 16'h0000;
    logic [5:0] eh = 6'h00;
    logic ld = 1'b0;
    logic [5:0] ldf = 6'h00;
    logic [5:0] cur_f, f_o;
    logic busy, done, wb, ww, wl, fwe, pwe;
    logic [15:0] res, m_word, m_pair;
    logic [7:0] m_byte;
    logic [21:0] pc, m_pc;
    int num_errors = 0;
    int samples_checked = 0;
    always #(alu_subset_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
    alu_subset dut (.i_sys_clk(clk), .i_reset(rst), .i_start(go), .i_op(op_s), .i_opa(a_s),
        .i_opb(b_s), .i_z_ptr(zp), .i_ext_indirect_high(eh), .i_flags(cur_f), .o_busy(busy),
        .o_done(done), .o_result(res), .o_wr_byte(wb), .o_wr_word(ww), .o_wr_low_pair(wl),
        .o_flags(f_o), .o_flags_we(fwe), .o_pc(pc), .o_pc_we(pwe));
    reg_file_model mdl (.i_sys_clk(clk), .i_reset(rst), .i_load(ld), .i_load_flags(ldf),
        .i_result(res), .i_wr_byte(wb), .i_wr_word(ww), .i_wr_low_pair(wl), .i_flags(f_o),
        .i_flags_we(fwe), .i_pc(pc), .i_pc_we(pwe), .o_byte(m_byte), .o_word(m_word),
        .o_low_pair(m_pair), .o_flags(cur_f), .o_pc(m_pc));
    task automatic summarize;
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [21:0] got, input logic [21:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    task automatic do_op(input alu_subset_pkg::alu_op_t op, input logic [15:0] a,
            input logic [7:0] b, input int cyc);
        int n;
        go = 1'b1;
        op_s = op;
        a_s = a;
        b_s = b;
        tick();
        go = 1'b0;
        chk(22'(busy), 22'(cyc == 2), "busy");
        n = 1;
        while (done !== 1'b1 && n < 8) begin
            tick();
            n++;
        end
        chk(22'(n), 22'(cyc), "latency");
    endtask
    function automatic logic [21:0] exp_of(input alu_subset_pkg::alu_op_t op,
            input logic [15:0] a, input logic [7:0] b, input logic [5:0] f);
        logic [16:0] w;
        logic [8:0] r;
        logic [4:0] h;
        logic [15:0] p;
        logic [5:0] g;
        logic add;
        g = f;
        add = op == alu_subset_pkg::OP_ADD_IMM_WORD;
        w = add ? {1'b0, a} + {9'h000, b} : {1'b0, a} - {9'h000, b};
        r = {1'b0, a[7:0] & b};
        h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, f[0]};
        p = {{8{a[7]}}, a[7:0]} * {8'h00, b};
        case (op)
            alu_subset_pkg::OP_ADD_IMM_WORD, alu_subset_pkg::OP_SUB_IMM_WORD: begin
                g[0] = w[16];
                g[3] = add ? ~a[15] & w[15] : a[15] & ~w[15];
                g[1] = w[15:0] == 16'h0000;
                g[2] = w[15];
                g[4] = w[15] ^ g[3];
                return {g, w[15:0]};
            end
            alu_subset_pkg::OP_MUL_MIXED_SIGN, alu_subset_pkg::OP_FRAC_MUL_MIXED_SIGN: begin
                g[0] = p[15];
                if (op == alu_subset_pkg::OP_FRAC_MUL_MIXED_SIGN) p = p << 1;
                g[1] = p == 16'h0000;
                return {g, p};
            end
            alu_subset_pkg::OP_SUB_IMM_BORROW: begin
                r = {1'b0, a[7:0]} - {1'b0, b} - {8'h00, f[0]};
                g[0] = r[8];
                g[5] = h[4];
                g[3] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
            end
            alu_subset_pkg::OP_OR_IMM, alu_subset_pkg::OP_SET_MASK_BITS: r = {1'b0, a[7:0] | b};
            alu_subset_pkg::OP_CLEAR_MASK_BITS: r = {1'b0, a[7:0] & ~b};
            alu_subset_pkg::OP_TEST_ZERO_MINUS: r = {1'b0, a[7:0]};
            default: g[3] = 1'b0;
        endcase
        // Logic ops clear V; multiplies returned above and keep it
        if (op != alu_subset_pkg::OP_SUB_IMM_BORROW) g[3] = 1'b0;
        g[1] = r[7:0] == 8'h00;
        g[2] = r[7];
        g[4] = r[7] ^ g[3];
        return {g, 8'h00, r[7:0]};
    endfunction
    task automatic set_f(input logic [5:0] f);
        ld = 1'b1;
        ldf = f;
        tick();
        ld = 1'b0;
    endtask
    // Runs one op from preloaded flags and checks outputs, strobes and stored state
    task automatic check_op(input alu_subset_pkg::alu_op_t op, input logic [15:0] a,
            input logic [7:0] b, input logic [5:0] f);
        logic [21:0] e;
        logic [4:0] s;
        e = exp_of(op, a, b, f);
        s[4] = op inside {[alu_subset_pkg::OP_SUB_IMM_BORROW:alu_subset_pkg::OP_CLEAR_MASK_BITS]};
        s[3] = op inside {alu_subset_pkg::OP_ADD_IMM_WORD, alu_subset_pkg::OP_SUB_IMM_WORD};
        s[2] = op inside {alu_subset_pkg::OP_MUL_MIXED_SIGN, alu_subset_pkg::OP_FRAC_MUL_MIXED_SIGN};
        s[1:0] = 2'b10;
        set_f(f);
        do_op(op, a, b, (s[3] | s[2]) ? 2 : 1);
        chk(22'(res), 22'(e[15:0]), "result");
        chk(22'(f_o), 22'(e[21:16]), "flags");
        chk(22'({wb, ww, wl, fwe, pwe}), 22'(s), "strobes");
        tick();
        chk(22'(done), 22'h0, "done pulse");
        chk(22'(cur_f), 22'(e[21:16]), "stored flags");
        if (s[4]) chk(22'(m_byte), 22'(e[7:0]), "stored byte");
        if (s[3]) chk(22'(m_word), 22'(e[15:0]), "stored word");
        if (s[2]) chk(22'(m_pair), 22'(e[15:0]), "stored pair");
    endtask
    task automatic t_word;
        check_op(alu_subset_pkg::OP_ADD_IMM_WORD, 16'hffc1, 8'h3f, 6'h20);
        check_op(alu_subset_pkg::OP_ADD_IMM_WORD, 16'h7fff, 8'h01, 6'h00);
        check_op(alu_subset_pkg::OP_SUB_IMM_WORD, 16'h0000, 8'h01, 6'h21);
        check_op(alu_subset_pkg::OP_SUB_IMM_WORD, 16'h8000, 8'h01, 6'h00);
        $display("test word done");
    endtask
    task automatic t_byte;
        check_op(alu_subset_pkg::OP_SUB_IMM_BORROW, 16'h0010, 8'h01, 6'h03);
        check_op(alu_subset_pkg::OP_SUB_IMM_BORROW, 16'h0080, 8'h00, 6'h03);
        check_op(alu_subset_pkg::OP_SUB_IMM_BORROW, 16'h0001, 8'h00, 6'h03);
        check_op(alu_subset_pkg::OP_AND_IMM, 16'hff5a, 8'h0f, 6'h3f);
        check_op(alu_subset_pkg::OP_OR_IMM, 16'h0080, 8'h01, 6'h08);
        check_op(alu_subset_pkg::OP_SET_MASK_BITS, 16'h0000, 8'h00, 6'h21);
        check_op(alu_subset_pkg::OP_CLEAR_MASK_BITS, 16'h00f3, 8'hf0, 6'h09);
        check_op(alu_subset_pkg::OP_TEST_ZERO_MINUS, 16'h0080, 8'h55, 6'h21);
        check_op(alu_subset_pkg::OP_TEST_ZERO_MINUS, 16'h1200, 8'hff, 6'h0c);
        $display("test byte done");
    endtask
    task automatic t_mul;
        check_op(alu_subset_pkg::OP_MUL_MIXED_SIGN, 16'h00ff, 8'hff, 6'h3c);
        check_op(alu_subset_pkg::OP_MUL_MIXED_SIGN, 16'h0000, 8'h12, 6'h01);
        check_op(alu_subset_pkg::OP_FRAC_MUL_MIXED_SIGN, 16'h0040, 8'h80, 6'h03);
        check_op(alu_subset_pkg::OP_FRAC_MUL_MIXED_SIGN, 16'h0080, 8'h80, 6'h00);
        $display("test multiply done");
    endtask
    task automatic t_jump;
        set_f(6'h2d);
        zp = 16'hbeef;
        eh = 6'h2a;
        do_op(alu_subset_pkg::OP_EXT_INDIRECT_JUMP, 16'h0000, 8'h00, 2);
        chk(pc, 22'h2abeef, "ext jump pc");
        chk(22'({fwe, pwe}), 22'h1, "ext jump strobes");
        zp = 16'h1234;
        do_op(alu_subset_pkg::OP_INDIRECT_JUMP, 16'h0000, 8'h00, 2);
        chk(pc, 22'h001234, "jump pc");
        tick();
        chk(m_pc, 22'h001234, "stored pc");
        chk(22'(cur_f), 22'h2d, "flags kept");
        $display("test jump done");
    endtask
    task automatic t_seq;
        go = 1'b1;
        op_s = alu_subset_pkg::OP_ADD_IMM_WORD;
        a_s = 16'h0102;
        b_s = 8'h03;
        tick();
        op_s = alu_subset_pkg::OP_AND_IMM;
        tick();
        go = 1'b0;
        chk(22'({done, res}), 22'h10105, "busy refusal");
        tick();
        chk(22'(done), 22'h0, "refused start");
        go = 1'b1;
        b_s = 8'h0f;
        tick();
        chk(22'({done, res}), 22'h10002, "first of pair");
        op_s = alu_subset_pkg::OP_OR_IMM;
        tick();
        go = 1'b0;
        chk(22'({done, res}), 22'h1000f, "second of pair");
        $display("test sequence done");
    endtask
    initial begin
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        t_word();
        t_byte();
        t_mul();
        t_jump();
        t_seq();
        summarize();
    end
    initial begin
        #(LIMIT * alu_subset_pkg::CLK_PERIOD_NS);
        num_errors++;
        summarize();
    end
endmodule
`default_nettype wire
